// File: common/sbs_pkg.sv
package sbs_pkg;
  // register word indices; byte address is four times the index
  localparam logic [19:0] SBS_IDX_CONTROL = 20'h0_ff78;
  localparam logic [19:0] SBS_IDX_STATUS  = 20'h0_ff79;
  localparam logic [19:0] SBS_IDX_EVENTS  = 20'h0_ff7a;
  localparam logic [19:0] SBS_IDX_EV_EN   = 20'h0_ff7b;
  localparam logic [19:0] SBS_IDX_EV_CLR  = 20'h0_ff7c;
  localparam int          SBS_AW          = 22;
  // control bit positions
  localparam int SBS_C_STOP = 0;
  localparam int SBS_C_START = 1;
  localparam int SBS_C_ACKE = 2;
  localparam int SBS_C_WTIM = 3;
  localparam int SBS_C_SPIE = 4;
  localparam int SBS_C_WREL = 5;
  localparam int SBS_C_LREL = 6;
  localparam int SBS_C_ENA = 7;
  // status bit positions
  localparam int SBS_S_SPD = 0;
  localparam int SBS_S_STD = 1;
  localparam int SBS_S_ACKD = 2;
  localparam int SBS_S_TRC = 3;
  localparam int SBS_S_COI = 4;
  localparam int SBS_S_EXC = 5;
  localparam int SBS_S_ALD = 6;
  localparam int SBS_S_MSTS = 7;
  localparam logic [7:0] SBS_RST_BYTE = 8'h00;
  // event bits: wait entered, stop seen, arbitration lost
  localparam int SBS_NEV = 3;
  localparam int SBS_E_WAIT = 0;
  localparam int SBS_E_STOP = 1;
  localparam int SBS_E_ALD = 2;
  // clock-count points for wait and acknowledge
  localparam logic [3:0] SBS_CLK8 = 4'h8;
  localparam logic [3:0] SBS_CLK9 = 4'h9;
  // line timing: 250 MHz system clock
  localparam int SBS_CLK_MHZ = 250;
  localparam int SBS_T_LOW_NS = 4700;
  localparam int SBS_T_SU_NS = 4000;
  localparam int SBS_LOW_CYC = (SBS_T_LOW_NS * SBS_CLK_MHZ + 999) / 1000;
  localparam int SBS_SU_CYC = (SBS_T_SU_NS * SBS_CLK_MHZ + 999) / 1000;
  localparam logic [1:0] SBS_RESP_OK = 2'h0;
  localparam logic [1:0] SBS_RESP_ERR = 2'h2;
  // stop sequencer states
  typedef enum logic [2:0] {
    SBS_IDLE    = 3'b000,
    SBS_SDA_LOW = 3'b001,
    SBS_SCL_UP  = 3'b010,
    SBS_SETUP   = 3'b011,
    SBS_RELEASE = 3'b100
  } sbs_state_t;
  // open-drain pin pair as seen by the block
  typedef struct packed {
    logic scl;
    logic sda;
  } sbs_line_t;
  // events from the byte engine on the same clock
  typedef struct packed {
    logic arb_lost;
    logic master_start;
    logic trc_set;
    logic addr_match;
    logic ext_code;
    logic tx_sda_low;
  } sbs_evt_t;
endpackage : sbs_pkg

// File: hw/sbs_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for pin inputs
module sbs_sync import sbs_pkg::*; #(
  parameter int W = 2
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta; // first stage, read only by the second
  // lines idle high, so reset to released level
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta     <= '1;
      sync_out <= '1;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : sbs_sync

// File: hw/sbs_irq.sv
`timescale 1ns/1ps
// sticky event bits, enable mask, one level interrupt
module sbs_irq import sbs_pkg::*; #(
  parameter int N = SBS_NEV
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] ev_set,
  input  wire logic [N-1:0] ev_clr,
  input  wire logic         en_we,
  input  wire logic [N-1:0] en_wdata,
  output logic      [N-1:0] ev_status,
  output logic      [N-1:0] ev_enable,
  output logic              irq
);
  logic [N-1:0] next_status; // sticky bits
  logic [N-1:0] next_enable; // mask
  // set wins over a clear in the same cycle
  always_comb begin
    next_status = (ev_status & ~ev_clr) | ev_set;
    next_enable = en_we ? en_wdata : ev_enable;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ev_status <= '0;
      ev_enable <= '0;
    end else begin
      ev_status <= next_status;
      ev_enable <= next_enable;
    end
  end
  assign irq = |(ev_status & ev_enable);
endmodule : sbs_irq

// File: hw/sbs_stop_ctrl.sv
`timescale 1ns/1ps
module sbs_stop_ctrl import sbs_pkg::*; #(
  parameter int LOW_CYC = SBS_LOW_CYC,
  parameter int SU_CYC  = SBS_SU_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic [SBS_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [SBS_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire sbs_line_t         line_in,
  output sbs_line_t              line_out,
  output sbs_line_t              line_oe,
  input  wire sbs_evt_t          evt,
  output logic                   start_request,
  output logic                   irq
);
  localparam logic [11:0] LOW_N = 12'(LOW_CYC - 1);
  localparam logic [11:0] SU_N  = 12'(SU_CYC - 1);
  localparam logic [SBS_AW-1:0] A_CTL = SBS_AW'({SBS_IDX_CONTROL, 2'b00});
  localparam logic [SBS_AW-1:0] A_STS = SBS_AW'({SBS_IDX_STATUS, 2'b00});
  localparam logic [SBS_AW-1:0] A_EV  = SBS_AW'({SBS_IDX_EVENTS, 2'b00});
  localparam logic [SBS_AW-1:0] A_EN  = SBS_AW'({SBS_IDX_EV_EN, 2'b00});
  localparam logic [SBS_AW-1:0] A_CLR = SBS_AW'({SBS_IDX_EV_CLR, 2'b00});

  sbs_line_t       ln;           // synchronised lines
  sbs_line_t       ln_d;         // previous sample for edges
  logic [7:0]      ctl;          // control register
  logic [7:0]      sts;          // status register
  sbs_state_t      st;           // stop sequencer
  logic [11:0]     cnt;          // sequencer timer
  logic            scl_keep_low; // clock was low when stop began
  logic [3:0]      nclk;         // clock rises in this byte
  logic            wait_hold;    // clock held low for wait
  logic            aw_ok, w_ok;  // write halves taken
  logic [SBS_AW-1:0] aw_q;
  logic [31:0]     w_q;
  logic [SBS_NEV-1:0] ev_st, ev_en;

  // pin inputs pass two flops before use
  sbs_sync #(.W(2)) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (line_in),
    .sync_out (ln)
  );

  // line edge and condition detection
  logic scl_rise, scl_fall, start_seen, stop_seen;
  always_comb begin
    scl_rise   = ln.scl & ~ln_d.scl;
    scl_fall   = ~ln.scl & ln_d.scl;
    start_seen = ln.scl & ln_d.scl & ln_d.sda & ~ln.sda;
    stop_seen  = ln.scl & ln_d.scl & ~ln_d.sda & ln.sda;
  end

  // write decode: both halves held, response not yet given
  logic wr_go, rd_go, en;
  logic [7:0] wb;
  always_comb begin
    wr_go = aw_ok & w_ok & ~s_axi_bvalid;
    rd_go = s_axi_arvalid & s_axi_arready;
    wb    = w_q[7:0];
    en    = ctl[SBS_C_ENA];
  end
  logic w_q_strb0; // low byte lane enabled
  logic [3:0] strb_q;
  assign w_q_strb0 = strb_q[0];
  logic wr_ctl, wr_en, wr_clr, wr_known;
  always_comb begin
    wr_ctl = 1'b0;
    wr_en = 1'b0;
    wr_clr = 1'b0;
    wr_known = 1'b1;
    if (aw_q == A_CTL) begin
      wr_ctl = wr_go & w_q_strb0;
    end else if (aw_q == A_EN) begin
      wr_en = wr_go & w_q_strb0;
    end else if (aw_q == A_CLR) begin
      wr_clr = wr_go & w_q_strb0;
    end else if (aw_q == A_STS || aw_q == A_EV) begin
      wr_known = 1'b1; // read-only, write ignored
    end else begin
      wr_known = 1'b0;
    end
  end
  // wait point chosen by wait timing bit
  logic wtim, at8, at9, wait_pt, wrel, lrel;
  always_comb begin
    // flags count only while interface enabled
    wtim = ctl[SBS_C_WTIM] & en;
    at8  = nclk == SBS_CLK8;
    at9  = nclk == SBS_CLK9;
    wait_pt = scl_fall & en & (wtim ? at9 : at8);
    wrel = wr_ctl & wb[SBS_C_WREL] & en;
    lrel = wr_ctl & wb[SBS_C_LREL] & en;
  end

  // stop sequencer next state
  sbs_state_t next_st;
  logic [11:0] next_cnt;
  logic next_keep, go, abort;
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_keep = scl_keep_low;
    abort = ~en | evt.arb_lost | lrel;
    // wait after 8th with timing 0 waits for release
    go = ctl[SBS_C_STOP] & en & (~wait_hold | (wtim & at9) | wrel);
    case (st)
      SBS_IDLE: begin
        if (go) begin
          next_st = SBS_SDA_LOW;
          next_cnt = LOW_N;
          next_keep = ~ln.scl;
        end
      end
      // data low before clock goes high
      SBS_SDA_LOW: begin
        if (cnt == '0) begin
          next_st = SBS_SCL_UP;
        end else begin
          next_cnt = cnt - 12'h001;
        end
      end
      // wait for clock to read high, stretching honoured
      SBS_SCL_UP: begin
        if (ln.scl) begin
          next_st = SBS_SETUP;
          next_cnt = SU_N;
        end
      end
      // setup interval counted on system clock
      SBS_SETUP: begin
        if (cnt == '0) begin
          next_st = SBS_RELEASE;
        end else begin
          next_cnt = cnt - 12'h001;
        end
      end
      // data released, stop forms on the bus
      SBS_RELEASE: begin
        if (ln.sda) begin
          next_st = SBS_IDLE;
        end
      end
      default: next_st = SBS_IDLE;
    endcase
    if (abort) begin
      next_st = SBS_IDLE;
    end
  end

  // control, status, wait and counter next values
  logic [7:0] next_ctl, next_sts;
  logic [3:0] next_nclk;
  logic next_wait;
  always_comb begin
    next_ctl = ctl;
    next_sts = sts;
    next_nclk = nclk;
    next_wait = wait_hold;
    if (wr_ctl) begin
      next_ctl = wb & ~(8'h01 << SBS_C_WREL) & ~(8'h01 << SBS_C_LREL);
    end
    if (evt.arb_lost | stop_seen | lrel | ~next_ctl[SBS_C_ENA]) begin
      next_ctl[SBS_C_STOP] = 1'b0;
    end
    if (evt.arb_lost | start_seen | lrel | ~next_ctl[SBS_C_ENA]) begin
      next_ctl[SBS_C_START] = 1'b0;
    end
    // byte clock counting and wait hold
    // count stays at 9 through a wait after the 9th clock, so wait
    // release and a stop there still see it; next byte restarts at 1
    if (start_seen | stop_seen | ~en) begin
      next_nclk = '0;
    end else if (scl_rise) begin
      next_nclk = at9 ? 4'h1 : nclk + 4'h1;
    end
    if (wait_pt) begin
      next_wait = 1'b1;
    end
    if (wrel | lrel | ~en | st != SBS_IDLE) begin
      next_wait = 1'b0;
    end
    // status flags at their bit positions
    if (start_seen) begin
      next_sts[SBS_S_STD] = 1'b1;
      next_sts[SBS_S_SPD] = 1'b0;
    end
    if (stop_seen) begin
      next_sts[SBS_S_SPD] = 1'b1;
      next_sts[SBS_S_STD] = 1'b0;
      next_sts[SBS_S_MSTS] = 1'b0;
    end
    if (start_seen | stop_seen | lrel) begin
      next_sts[SBS_S_COI] = 1'b0;
      next_sts[SBS_S_EXC] = 1'b0;
    end
    if (scl_rise & at8) begin
      next_sts[SBS_S_ACKD] = ~ln.sda;
    end
    if (rd_go & s_axi_araddr == A_STS) begin
      next_sts[SBS_S_ALD] = 1'b0;
    end
    if (lrel) begin
      next_sts[SBS_S_MSTS] = 1'b0;
      next_sts[SBS_S_TRC] = 1'b0;
    end
    // wait release at 9th clears transmit mode
    if (wrel & wait_hold & at9) begin
      next_sts[SBS_S_TRC] = 1'b0;
    end
    // set events win over the clears above; arbitration loss still clears master status
    if (evt.trc_set) next_sts[SBS_S_TRC] = 1'b1;
    if (evt.addr_match) next_sts[SBS_S_COI] = 1'b1;
    if (evt.ext_code) next_sts[SBS_S_EXC] = 1'b1;
    if (evt.master_start) next_sts[SBS_S_MSTS] = 1'b1;
    if (evt.arb_lost) begin
      next_sts[SBS_S_ALD] = 1'b1;
      next_sts[SBS_S_MSTS] = 1'b0;
    end
    // disabling clears the status
    if (~en) begin
      next_sts = SBS_RST_BYTE;
    end
  end

  // lines only pulled low, never driven high
  logic ack_drv;
  always_comb begin
    ack_drv = ctl[SBS_C_ACKE] & en & ~sts[SBS_S_TRC] & at8 & ~ln.scl;
    line_out = '0;
    line_oe.scl = wait_hold | (st == SBS_SDA_LOW & scl_keep_low);
    line_oe.sda = (st == SBS_SDA_LOW) | (st == SBS_SCL_UP) |
                  (st == SBS_SETUP) | ack_drv |
                  (sts[SBS_S_TRC] & evt.tx_sda_low & st == SBS_IDLE);
    start_request = ctl[SBS_C_START] & en;
  end

  // axi channel next values
  logic next_aw_ok, next_w_ok, next_bv, next_rv;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  always_comb begin
    s_axi_awready = ~aw_ok;
    s_axi_wready = ~w_ok;
    s_axi_arready = ~s_axi_rvalid;
    next_aw_ok = (aw_ok | s_axi_awvalid) & ~wr_go;
    next_w_ok = (w_ok | s_axi_wvalid) & ~wr_go;
    next_bv = wr_go | (s_axi_bvalid & ~s_axi_bready);
    next_bresp = wr_go ? (wr_known ? SBS_RESP_OK : SBS_RESP_ERR)
                       : s_axi_bresp;
    next_rv = rd_go | (s_axi_rvalid & ~s_axi_rready);
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (rd_go) begin
      next_rresp = SBS_RESP_OK;
      next_rdata = '0;
      if (s_axi_araddr == A_CTL) begin
        // trigger bits read back as zero
        next_rdata[7:0] = ctl & ~((8'h01 << SBS_C_STOP) |
                                  (8'h01 << SBS_C_START));
      end else if (s_axi_araddr == A_STS) begin
        next_rdata[7:0] = sts;
      end else if (s_axi_araddr == A_EV) begin
        next_rdata[SBS_NEV-1:0] = ev_st;
      end else if (s_axi_araddr == A_EN) begin
        next_rdata[SBS_NEV-1:0] = ev_en;
      end else if (s_axi_araddr != A_CLR) begin
        next_rresp = SBS_RESP_ERR;
      end
    end
  end

  // register every group
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ln_d <= '1;
      ctl <= SBS_RST_BYTE;
      sts <= SBS_RST_BYTE;
      st <= SBS_IDLE;
      cnt <= '0;
      scl_keep_low <= 1'b0;
      nclk <= '0;
      wait_hold <= 1'b0;
      aw_ok <= 1'b0;
      w_ok <= 1'b0;
      aw_q <= '0;
      w_q <= '0;
      strb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SBS_RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= SBS_RESP_OK;
      s_axi_rdata <= '0;
    end else begin
      ln_d <= ln;
      ctl <= next_ctl;
      sts <= next_sts;
      st <= next_st;
      cnt <= next_cnt;
      scl_keep_low <= next_keep;
      nclk <= next_nclk;
      wait_hold <= next_wait;
      aw_ok <= next_aw_ok;
      w_ok <= next_w_ok;
      if (s_axi_awvalid & ~aw_ok) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid & ~w_ok) w_q <= s_axi_wdata;
      if (s_axi_wvalid & ~w_ok) strb_q <= s_axi_wstrb;
      s_axi_bvalid <= next_bv;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rv;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

  // events: wait entered, stop seen (if enabled), arbitration lost
  logic [SBS_NEV-1:0] ev_set;
  always_comb begin
    ev_set = '0;
    ev_set[SBS_E_WAIT] = wait_pt;
    ev_set[SBS_E_STOP] = stop_seen & ctl[SBS_C_SPIE] & en;
    ev_set[SBS_E_ALD] = evt.arb_lost;
  end
  sbs_irq #(.N(SBS_NEV)) u_irq (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .ev_set    (ev_set),
    .ev_clr    (wr_clr ? w_q[SBS_NEV-1:0] : '0),
    .en_we     (wr_en),
    .en_wdata  (w_q[SBS_NEV-1:0]),
    .ev_status (ev_st),
    .ev_enable (ev_en),
    .irq       (irq)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_data_before_clk: assert property (
    st == SBS_SCL_UP |-> line_oe.sda && !line_oe.scl)
    else $error("data not low while clock released");
  chk_setup_then_rel: assert property (
    $rose(st == SBS_RELEASE) |-> $past(st) == SBS_SETUP && !line_oe.sda)
    else $error("data release without setup");
  chk_trig_clear: assert property (
    (evt.arb_lost || stop_seen) |=> !ctl[SBS_C_STOP])
    else $error("stop trigger not cleared");
  chk_stop_at_nine: assert property (
    wait_hold && !wtim && ctl[SBS_C_STOP] && !wrel && en |=> st == SBS_IDLE)
    else $error("stop started before wait release");
  chk_trc_clear: assert property (
    wrel && wait_hold && at9 && !evt.trc_set |=> !sts[SBS_S_TRC])
    else $error("transmit flag kept after wait release");
  chk_trig_read_zero: assert property (
    s_axi_rvalid && s_axi_rresp == SBS_RESP_OK |-> s_axi_rdata[1:0] == 2'b00
      || $past(s_axi_araddr) != A_CTL)
    else $error("trigger bits read non-zero");
  chk_disabled_quiet: assert property (
    !en && !wr_ctl |=> !line_oe.scl && !line_oe.sda && !start_request
      && st == SBS_IDLE)
    else $error("acting while interface disabled");
  chk_setup_len: assert property (
    $rose(st == SBS_SETUP) |-> (st != SBS_RELEASE)[*8])
    else $error("setup interval too short");
  chk_only_low: assert property (
    line_out == '0)
    else $error("line driven high");
  cov_stop_done: cover property (st == SBS_RELEASE ##1 st == SBS_IDLE);
  cov_wait8: cover property (wait_pt && !wtim);
  cov_wait9: cover property (wait_pt && wtim);
  cov_irq: cover property ($rose(irq));
endmodule : sbs_stop_ctrl

// File: verification/sbs_bus_model.sv
`timescale 1ns/1ps
// far side: pull-ups, a clocking party and a stop watcher
module sbs_bus_model import sbs_pkg::*; (
  input  wire sbs_line_t dut_oe,
  output sbs_line_t      line
);
  logic scl_low;  // far side pulls the clock low
  int   stop_cnt; // stops seen on the wire
  assign line = {!(dut_oe.scl || scl_low), !dut_oe.sda};
  initial begin
    scl_low  = 1'b0;
    stop_cnt = 0;
  end
  always @(posedge line.sda) begin
    if (line.scl) begin
      stop_cnt++;
    end
  end
  // n pulses at 160 ns, then the clock is released; a wait hold keeps it low after
  task automatic clocks(input int n);
    // step off the system clock edge so the synchroniser never races
    #1;
    scl_low = 1'b1;
    #80;
    for (int i = 0; i < n; i++) begin
      scl_low = 1'b0;
      #80;
      scl_low = 1'b1;
      #80;
    end
    scl_low = 1'b0;
  endtask : clocks
endmodule : sbs_bus_model

// File: verification/tb.sv
`timescale 1ns/1ps
module tb import sbs_pkg::*; ;
  localparam int SU = 8;  // shortened setup count
  localparam logic [21:0] A_CTL = {SBS_IDX_CONTROL, 2'b00};
  localparam logic [21:0] A_STA = {SBS_IDX_STATUS, 2'b00};
  localparam logic [21:0] A_EV  = {SBS_IDX_EVENTS, 2'b00};
  localparam logic [21:0] A_EN  = {SBS_IDX_EV_EN, 2'b00};
  localparam logic [21:0] A_CLR = {SBS_IDX_EV_CLR, 2'b00};
  localparam logic [21:0] A_BAD = 22'h0_0000; // unmapped
  logic ref_clk, rst_n;
  logic [21:0] awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  sbs_line_t   line_in, line_out, line_oe;
  sbs_evt_t    evt;
  logic        start_request, irq;
  int          n_fail, samples_checked;

  sbs_stop_ctrl #(.LOW_CYC(4), .SU_CYC(SU)) u_sbs_stop_ctrl (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
    .evt(evt), .start_request(start_request), .irq(irq));
  sbs_bus_model u_sbs_bus_model (.dut_oe(line_oe), .line(line_in));

  // 250 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  // write: address and data offered together, each held until taken
  task automatic wr(input logic [21:0] a, input logic [7:0] d,
                    output logic [1:0] resp);
    logic ap, wp, ta, tw, b;
    @(posedge ref_clk);
    awaddr <= a; wdata <= {24'h00_0000, d}; wstrb <= 4'h1;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    ap = 1'b1; wp = 1'b1; b = 1'b0;
    while (ap || wp) begin
      @(negedge ref_clk);
      ta = ap && awready; tw = wp && wready;
      @(posedge ref_clk);
      if (ta) begin awvalid <= 1'b0; ap = 1'b0; end
      if (tw) begin wvalid <= 1'b0; wp = 1'b0; end
    end
    while (!b) begin
      @(negedge ref_clk);
      b = bvalid; resp = bresp;
      @(posedge ref_clk);
    end
    bready <= 1'b0;
  endtask : wr

  task automatic wrc(input logic [21:0] a, input logic [7:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk(r, SBS_RESP_OK, "bresp");
  endtask : wrc

  task automatic rd(input logic [21:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    logic t, v;
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    t = 1'b0; v = 1'b0;
    while (!t) begin
      @(negedge ref_clk);
      t = arready;
      @(posedge ref_clk);
    end
    arvalid <= 1'b0;
    while (!v) begin
      @(negedge ref_clk);
      v = rvalid; d = rdata; resp = rresp;
      @(posedge ref_clk);
    end
    rready <= 1'b0;
  endtask : rd

  task automatic rdc(input logic [21:0] a, input logic [31:0] e,
                     input string what);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(r, SBS_RESP_OK, "rresp");
    chk(d, e, what);
  endtask : rdc

  task automatic pulse_start();
    @(posedge ref_clk);
    evt.master_start <= 1'b1;
    @(posedge ref_clk);
    evt.master_start <= 1'b0;
  endtask : pulse_start

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rdc(A_CTL, 32'h0000_0000, "ctl reset");
    rdc(A_STA, 32'h0000_0000, "status reset");
    rdc(A_EV, 32'h0000_0000, "events reset");
    wrc(A_STA, 8'hff);
    rdc(A_STA, 32'h0000_0000, "status read-only");
    rd(A_BAD, d, r);
    chk(r, SBS_RESP_ERR, "unmapped read");
  endtask : t_reset

  task automatic t_stop();
    int s0, n, k;
    s0 = u_sbs_bus_model.stop_cnt;
    wrc(A_CTL, 8'h91);
    rdc(A_CTL, 32'h0000_0090, "trigger reads zero");
    for (n = 0; n < 100 && !(line_oe.sda && line_in.scl); n++) cyc(1);
    chk(line_oe.sda && line_in.scl, 1'b1, "data low, clock high");
    k = 0;
    for (n = 0; n < 100 && line_oe.sda; n++) begin
      cyc(1);
      if (line_in.scl) k++;
    end
    chk(k >= SU, 1'b1, "setup before release");
    cyc(50);
    chk(u_sbs_bus_model.stop_cnt, s0 + 1, "one stop formed");
    rdc(A_STA, 32'h0000_0001, "stop detected bit");
    rdc(A_EV, 32'h0000_0002, "stop event");
    wrc(A_EN, 8'h02);
    cyc(2);
    chk(irq, 1'b1, "irq enabled");
    wrc(A_EN, 8'h00);
    cyc(2);
    chk(irq, 1'b0, "irq masked");
    wrc(A_EN, 8'h02);
    wrc(A_CLR, 8'h02);
    cyc(2);
    chk(irq, 1'b0, "irq cleared");
    rdc(A_EV, 32'h0000_0000, "event cleared");
  endtask : t_stop

  task automatic t_wait8();
    int s0;
    s0 = u_sbs_bus_model.stop_cnt;
    wrc(A_CTL, 8'h80);
    pulse_start();
    u_sbs_bus_model.clocks(8);
    cyc(20);
    chk(line_oe.scl, 1'b1, "hold after 8th");
    rdc(A_EV, 32'h0000_0001, "wait event");
    wrc(A_CTL, 8'h81);
    cyc(10);
    chk(line_oe.sda, 1'b0, "stop waits for release");
    wrc(A_CTL, 8'ha1);
    cyc(10);
    chk(line_oe.scl, 1'b0, "wait released");
    cyc(30);
    chk(u_sbs_bus_model.stop_cnt, s0 + 1, "stop on 9th clock");
    wrc(A_CLR, 8'h07);
  endtask : t_wait8

  task automatic t_wait9();
    logic [31:0] d;
    logic [1:0]  r;
    wrc(A_CTL, 8'h88);
    pulse_start();
    @(posedge ref_clk);
    evt.trc_set <= 1'b1;
    @(posedge ref_clk);
    evt.trc_set <= 1'b0;
    u_sbs_bus_model.clocks(9);
    cyc(20);
    chk(line_oe.scl, 1'b1, "hold after 9th");
    @(posedge ref_clk);
    evt.tx_sda_low <= 1'b1;
    cyc(3);
    chk(line_oe.sda, 1'b1, "transmit drives data");
    rd(A_STA, d, r);
    chk(d[SBS_S_TRC], 1'b1, "transmit flag set");
    wrc(A_CTL, 8'ha8);
    cyc(10);
    rd(A_STA, d, r);
    chk(d[SBS_S_TRC], 1'b0, "transmit flag cleared");
    chk(line_oe.sda, 1'b0, "data high impedance");
    evt.tx_sda_low <= 1'b0;
    wrc(A_CLR, 8'h07);
  endtask : t_wait9

  task automatic t_arb();
    int s0;
    s0 = u_sbs_bus_model.stop_cnt;
    // disabling restarts the byte clock count
    wrc(A_CTL, 8'h00);
    wrc(A_CTL, 8'h80);
    pulse_start();
    u_sbs_bus_model.clocks(8);
    cyc(20);
    wrc(A_CTL, 8'h81);
    cyc(20);
    chk(line_oe.sda, 1'b0, "stop deferred in 8th wait");
    @(posedge ref_clk);
    evt.arb_lost <= 1'b1;
    @(posedge ref_clk);
    evt.arb_lost <= 1'b0;
    wrc(A_CTL, 8'ha0);
    u_sbs_bus_model.clocks(1);
    cyc(60);
    chk(u_sbs_bus_model.stop_cnt, s0, "no stop after arb loss");
    rdc(A_EV, 32'h0000_0005, "wait and arb events");
    wrc(A_CLR, 8'h07);
  endtask : t_arb

  task automatic t_disable();
    int s0;
    s0 = u_sbs_bus_model.stop_cnt;
    wrc(A_CTL, 8'h01);
    cyc(30);
    chk(line_oe, 2'b00, "disabled lines idle");
    chk(u_sbs_bus_model.stop_cnt, s0, "disabled no stop");
    rdc(A_STA, 32'h0000_0000, "disabled status");
    wrc(A_CTL, 8'h82);
    cyc(2);
    chk(start_request, 1'b1, "start request");
    wrc(A_CTL, 8'h00);
    cyc(2);
    chk(start_request, 1'b0, "enable low clears");
  endtask : t_disable

  // main sequence
  initial begin
    n_fail = 0; samples_checked = 0;
    rst_n = 1'b0; awaddr = '0; araddr = '0; wdata = '0; wstrb = '0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; evt = '0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_stop();
    t_wait8();
    t_wait9();
    t_arb();
    t_disable();
    complete_run();
  end

  // watchdog against a hang
  initial begin
    #200000;
    n_fail++;
    $display("ERROR %0t watchdog expired", $time);
    complete_run();
  end
endmodule : tb
